/* core/pfl_regs.sv */
// command registers, fault detection, status summary and output sequencing
// Contract
// - undervolt threshold keeps 10-bit unsigned value, 0.125 V per step
// - undervolt threshold reads as linear; linear writes need exponent -3
// - fault actions implement only ignore and latch codes
// - any detected fault pulls alert low and sets its status flag
// - ignore action keeps output regulating after the fault
// - latch action shuts output at once until cleared and re-enabled
// - ramp start delay is 8 bits of 0.5 ms from enable to rise
// - in a sharing group full delay only for bus or pin enable
// - overpower threshold is 10-bit unsigned, weight from current exponent setting
// - overpower linear writes need exponent +1; reads are linear
// - summary bit 7 flags a busy fault
// - summary bit 6 reads 1 whenever output is not powered
// - summary bits 5,4,3 flag vout over, iout over, vin under
// - summary bit 2 flags any temperature fault or warning
// - summary bit 1 flags communication, memory or logic faults
// - summary bit 0 flags faults not covered by bits 7 to 1
// - extended word bits 15..12 flag vout, iout/pout, input, maker faults
`timescale 1ns/1ns
module pfl_regs #(
    parameter int DELAY_STEP_CYCLES = pfl_pkg::DELAY_STEP_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // command register port
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic      [15:0] cmd_rdata,
    output logic             cmd_ack,
    output logic             cmd_err,
    // enables
    input  wire logic        bus_enable,
    input  wire logic        ctrl_pin,
    input  wire logic        group_enable,
    input  wire logic        share_group,
    input  wire logic        clear_faults,
    // measurements and system setting
    input  wire logic        meas_valid,
    input  wire logic [9:0]  vin_meas,
    input  wire logic [9:0]  pout_meas,
    input  wire logic [4:0]  current_exponent_setting,
    // fault events from elsewhere in the device
    input  wire logic        busy_event,
    input  wire logic        vout_ov_event,
    input  wire logic        vout_other_event,
    input  wire logic        iout_oc_event,
    input  wire logic        input_other_event,
    input  wire logic        temp_event,
    input  wire logic        cml_event,
    input  wire logic        mfr_event,
    input  wire logic        other_event,
    // power stage
    output logic             output_on,
    output logic             ramp_start,
    // open-drain alert
    output logic             alert_line_n_o,
    output logic             alert_line_n_oe
);

    // registers
    logic [9:0]  uv_thr;
    logic [9:0]  next_uv_thr;
    logic [7:0]  uv_act;
    logic [7:0]  next_uv_act;
    logic [7:0]  ramp_delay;
    logic [7:0]  next_ramp_delay;
    logic [9:0]  op_thr;
    logic [9:0]  next_op_thr;
    logic [7:0]  op_act;
    logic [7:0]  next_op_act;
    logic [15:0] next_cmd_rdata;
    logic        next_cmd_ack;
    logic        next_cmd_err;

    // sticky flags
    logic        f_busy;
    logic        f_vout_ov;
    logic        f_vout_oth;
    logic        f_iout_oc;
    logic        f_vin_uv;
    logic        f_pout_op;
    logic        f_input_oth;
    logic        f_temp;
    logic        f_cml;
    logic        f_mfr;
    logic        f_other;
    logic [10:0] flags;
    logic [10:0] next_flags;
    logic [10:0] flag_set;

    // sequencing
    pfl_pkg::pfl_state_t state;
    pfl_pkg::pfl_state_t next_state;
    logic [$clog2(DELAY_STEP_CYCLES+1)-1:0] div_cnt;
    logic [$clog2(DELAY_STEP_CYCLES+1)-1:0] next_div_cnt;
    logic [7:0]  step_cnt;
    logic [7:0]  next_step_cnt;
    logic        pin_meta;
    logic        pin_sync;
    logic        en_prev;
    logic        next_output_on;
    logic        next_ramp_start;
    logic        next_alert_oe;

    logic        enabled;
    logic        uv_trip;
    logic        op_trip;
    logic        latch_trip;
    logic        wr_reject;
    logic        unmapped;
    logic [7:0]  summary;
    logic [15:0] extended;
    logic [4:0]  wexp;

    assign {f_busy, f_vout_ov, f_vout_oth, f_iout_oc, f_vin_uv, f_pout_op,
            f_input_oth, f_temp, f_cml, f_mfr, f_other} = flags;

    assign enabled = bus_enable | pin_sync | group_enable;
    assign wexp    = cmd_wdata[15:pfl_pkg::THR_EXP_LSB];

    // measurement comparison against programmed limits
    assign uv_trip = meas_valid & (vin_meas < uv_thr);
    assign op_trip = meas_valid & (pout_meas > op_thr);

    // only the latch code shuts the output down; ignore leaves it running
    assign latch_trip = (uv_trip & (uv_act == pfl_pkg::ACT_LATCH))
                      | (op_trip & (op_act == pfl_pkg::ACT_LATCH));

    // summary byte
    always_comb begin
        summary                      = 8'h00;
        summary[pfl_pkg::SB_BUSY]    = f_busy;
        summary[pfl_pkg::SB_OFF]     = ~output_on;
        summary[pfl_pkg::SB_VOUT_OV] = f_vout_ov;
        summary[pfl_pkg::SB_IOUT_OC] = f_iout_oc;
        summary[pfl_pkg::SB_VIN_UV]  = f_vin_uv;
        summary[pfl_pkg::SB_TEMP]    = f_temp;
        summary[pfl_pkg::SB_CML]     = f_cml;
        // overpower, other vout, other input and maker faults have no bit above
        summary[pfl_pkg::SB_OTHER]   = f_pout_op | f_input_oth | f_other
                                     | f_vout_oth | f_mfr;
    end

    // extended word
    always_comb begin
        extended                         = {8'h00, summary};
        extended[pfl_pkg::SW_VOUT]       = f_vout_ov | f_vout_oth;
        extended[pfl_pkg::SW_IOUT_POUT]  = f_iout_oc | f_pout_op;
        extended[pfl_pkg::SW_INPUT]      = f_vin_uv | f_input_oth;
        extended[pfl_pkg::SW_MFR]        = f_mfr;
    end

    // write decode and command answers
    always_comb begin
        next_uv_thr     = uv_thr;
        next_uv_act     = uv_act;
        next_ramp_delay = ramp_delay;
        next_op_thr     = op_thr;
        next_op_act     = op_act;
        next_cmd_rdata  = cmd_rdata;
        next_cmd_ack    = 1'b0;
        next_cmd_err    = 1'b0;
        wr_reject       = 1'b0;
        unmapped        = 1'b0;
        if (cmd_wr) begin
            next_cmd_ack = 1'b1;
            unique case (cmd_code)
                pfl_pkg::CMD_UV_THRESHOLD: begin
                    if (wexp == pfl_pkg::EXP_RAW || wexp == pfl_pkg::EXP_UV_LINEAR) begin
                        next_uv_thr = cmd_wdata[pfl_pkg::THR_MANT_MSB:0];
                    end else begin
                        wr_reject = 1'b1;
                    end
                end
                pfl_pkg::CMD_UV_ACTION: begin
                    if (cmd_wdata[7:0] == pfl_pkg::ACT_IGNORE
                        || cmd_wdata[7:0] == pfl_pkg::ACT_LATCH) begin
                        next_uv_act = cmd_wdata[7:0];
                    end else begin
                        wr_reject = 1'b1;
                    end
                end
                pfl_pkg::CMD_RAMP_DELAY: begin
                    next_ramp_delay = cmd_wdata[7:0];
                end
                pfl_pkg::CMD_OP_THRESHOLD: begin
                    if (wexp == pfl_pkg::EXP_RAW || wexp == pfl_pkg::EXP_OP_LINEAR) begin
                        next_op_thr = cmd_wdata[pfl_pkg::THR_MANT_MSB:0];
                    end else begin
                        wr_reject = 1'b1;
                    end
                end
                pfl_pkg::CMD_OP_ACTION: begin
                    if (cmd_wdata[7:0] == pfl_pkg::ACT_IGNORE
                        || cmd_wdata[7:0] == pfl_pkg::ACT_LATCH) begin
                        next_op_act = cmd_wdata[7:0];
                    end else begin
                        wr_reject = 1'b1;
                    end
                end
                default: begin
                    // status registers are read only; writing them is refused
                    wr_reject = 1'b1;
                end
            endcase
        end else if (cmd_rd) begin
            next_cmd_ack = 1'b1;
            unique case (cmd_code)
                pfl_pkg::CMD_UV_THRESHOLD:
                    next_cmd_rdata = {pfl_pkg::EXP_UV_LINEAR, 1'b0, uv_thr};
                pfl_pkg::CMD_UV_ACTION:    next_cmd_rdata = {8'h00, uv_act};
                pfl_pkg::CMD_RAMP_DELAY:   next_cmd_rdata = {8'h00, ramp_delay};
                pfl_pkg::CMD_OP_THRESHOLD:
                    next_cmd_rdata = {current_exponent_setting, 1'b0, op_thr};
                pfl_pkg::CMD_OP_ACTION:    next_cmd_rdata = {8'h00, op_act};
                pfl_pkg::CMD_SUMMARY:      next_cmd_rdata = {8'h00, summary};
                pfl_pkg::CMD_EXTENDED:     next_cmd_rdata = extended;
                default: begin
                    next_cmd_rdata = 16'h0000;
                    unmapped       = 1'b1;
                end
            endcase
        end
        if (wr_reject || unmapped) begin
            next_cmd_err = 1'b1;
        end
    end

    // sticky fault flags, set wins over clear
    always_comb begin
        flag_set = {busy_event, vout_ov_event, vout_other_event, iout_oc_event,
                    uv_trip, op_trip, input_other_event, temp_event,
                    cml_event | wr_reject | unmapped, mfr_event, other_event};
        next_flags = (clear_faults ? 11'h000 : flags) | flag_set;
        next_alert_oe = |next_flags;
    end

    // output sequencing with turn-on delay
    always_comb begin
        next_state      = state;
        next_div_cnt    = div_cnt;
        next_step_cnt   = step_cnt;
        next_ramp_start = 1'b0;
        unique case (state)
            pfl_pkg::PFL_OFF: begin
                if (enabled && !en_prev) begin
                    next_div_cnt  = '0;
                    next_step_cnt = 8'h00;
                    // a group follower starts with its master, not after its own delay
                    if (share_group && !(bus_enable || pin_sync)) begin
                        next_state      = pfl_pkg::PFL_ON;
                        next_ramp_start = 1'b1;
                    end else if (ramp_delay == 8'h00) begin
                        next_state      = pfl_pkg::PFL_ON;
                        next_ramp_start = 1'b1;
                    end else begin
                        next_state      = pfl_pkg::PFL_DELAY;
                    end
                end
            end
            pfl_pkg::PFL_DELAY: begin
                if (!enabled) begin
                    next_state = pfl_pkg::PFL_OFF;
                end else if (div_cnt == $bits(div_cnt)'(DELAY_STEP_CYCLES - 1)) begin
                    next_div_cnt  = '0;
                    next_step_cnt = step_cnt + 8'h01;
                    if (step_cnt + 8'h01 == ramp_delay) begin
                        next_state      = pfl_pkg::PFL_ON;
                        next_ramp_start = 1'b1;
                    end
                end else begin
                    next_div_cnt = div_cnt + 1'b1;
                end
            end
            pfl_pkg::PFL_ON: begin
                if (!enabled) begin
                    next_state = pfl_pkg::PFL_OFF;
                end
            end
            pfl_pkg::PFL_LATCHED: begin
                // leaving needs a clear; the OFF state then waits for a fresh enable edge
                if (clear_faults) begin
                    next_state = pfl_pkg::PFL_OFF;
                end
            end
        endcase
        if (latch_trip) begin
            next_state      = pfl_pkg::PFL_LATCHED;
            next_ramp_start = 1'b0;
        end
        next_output_on = (next_state == pfl_pkg::PFL_ON);
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            uv_thr          <= pfl_pkg::RST_UV_THRESHOLD;
            uv_act          <= pfl_pkg::RST_UV_ACTION;
            ramp_delay      <= pfl_pkg::RST_RAMP_DELAY;
            op_thr          <= pfl_pkg::RST_OP_THRESHOLD;
            op_act          <= pfl_pkg::RST_OP_ACTION;
            cmd_rdata       <= 16'h0000;
            cmd_ack         <= 1'b0;
            cmd_err         <= 1'b0;
            flags           <= 11'h000;
            alert_line_n_oe <= 1'b0;
            alert_line_n_o  <= 1'b0;
            state           <= pfl_pkg::PFL_OFF;
            div_cnt         <= '0;
            step_cnt        <= 8'h00;
            pin_meta        <= 1'b0;
            pin_sync        <= 1'b0;
            en_prev         <= 1'b0;
            output_on       <= 1'b0;
            ramp_start      <= 1'b0;
        end else begin
            uv_thr          <= next_uv_thr;
            uv_act          <= next_uv_act;
            ramp_delay      <= next_ramp_delay;
            op_thr          <= next_op_thr;
            op_act          <= next_op_act;
            cmd_rdata       <= next_cmd_rdata;
            cmd_ack         <= next_cmd_ack;
            cmd_err         <= next_cmd_err;
            flags           <= next_flags;
            alert_line_n_oe <= next_alert_oe;
            alert_line_n_o  <= 1'b0;
            state           <= next_state;
            div_cnt         <= next_div_cnt;
            step_cnt        <= next_step_cnt;
            pin_meta        <= ctrl_pin;
            pin_sync        <= pin_meta;
            en_prev         <= enabled;
            output_on       <= next_output_on;
            ramp_start      <= next_ramp_start;
        end
    end

endmodule

/* core/pfl_pkg.sv */
// constants for the power fault, limit and status command registers
package pfl_pkg;

    // command codes
    localparam logic [7:0] CMD_UV_THRESHOLD  = 8'h59;
    localparam logic [7:0] CMD_UV_ACTION     = 8'h5A;
    localparam logic [7:0] CMD_RAMP_DELAY    = 8'h60;
    localparam logic [7:0] CMD_OP_THRESHOLD  = 8'h68;
    localparam logic [7:0] CMD_OP_ACTION     = 8'h69;
    localparam logic [7:0] CMD_SUMMARY       = 8'h78;
    localparam logic [7:0] CMD_EXTENDED      = 8'h79;

    // threshold layout
    localparam int         THR_MANT_MSB      = 9;
    localparam int         THR_EXP_LSB       = 11;
    localparam logic [4:0] EXP_RAW           = 5'h00;
    localparam logic [4:0] EXP_UV_LINEAR     = 5'h1D;
    localparam logic [4:0] EXP_OP_LINEAR     = 5'h01;

    // response codes
    localparam logic [7:0] ACT_IGNORE        = 8'h00;
    localparam logic [7:0] ACT_LATCH         = 8'h80;

    // summary byte bit positions
    localparam int         SB_BUSY           = 7;
    localparam int         SB_OFF            = 6;
    localparam int         SB_VOUT_OV        = 5;
    localparam int         SB_IOUT_OC        = 4;
    localparam int         SB_VIN_UV         = 3;
    localparam int         SB_TEMP           = 2;
    localparam int         SB_CML            = 1;
    localparam int         SB_OTHER          = 0;

    // extended word upper bit positions
    localparam int         SW_VOUT           = 15;
    localparam int         SW_IOUT_POUT      = 14;
    localparam int         SW_INPUT          = 13;
    localparam int         SW_MFR            = 12;

    // values after reset
    localparam logic [9:0] RST_UV_THRESHOLD  = 10'h000;
    localparam logic [7:0] RST_UV_ACTION     = 8'h00;
    localparam logic [7:0] RST_RAMP_DELAY    = 8'h00;
    localparam logic [9:0] RST_OP_THRESHOLD  = 10'h3FF;
    localparam logic [7:0] RST_OP_ACTION     = 8'h00;

    // timing
    localparam int         CLK_PERIOD_NS     = 20;
    localparam int         DELAY_STEP_NS     = 500000;
    localparam int         DELAY_STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PFL_OFF,
        PFL_DELAY,
        PFL_ON,
        PFL_LATCHED
    } pfl_state_t;

endpackage

/* testbench/pfl_host.sv */
// host-side command master model for the register port
`timescale 1ns/1ns
module pfl_host (
    // clock
    input  wire logic        mclk,
    // requests
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic      [7:0]  cmd_code,
    output logic      [15:0] cmd_wdata,
    // answers
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_ack,
    input  wire logic        cmd_err
);
    initial begin
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic a, output logic e, output logic [15:0] q);
        @(posedge mclk);
        cmd_wr    <= w;
        cmd_rd    <= !w;
        cmd_code  <= c;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_wr    <= 1'b0;
        cmd_rd    <= 1'b0;
        // released lines carry junk so a stale value is never mistaken for live
        cmd_code  <= ~c;
        cmd_wdata <= ~d;
        @(posedge mclk);
        a = cmd_ack;
        e = cmd_err;
        q = cmd_rdata;
    endtask
endmodule

/* testbench/pfl_regs_assertions.sv */
// port-level checker for the command register block
`timescale 1ns/1ns
module pfl_regs_assertions #(
    parameter int DELAY_STEP_CYCLES = 4
) (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        cmd_wr,
    input wire logic        cmd_rd,
    input wire logic [15:0] cmd_rdata,
    input wire logic        cmd_ack,
    input wire logic        cmd_err,
    input wire logic        bus_enable,
    input wire logic        ctrl_pin,
    input wire logic        group_enable,
    input wire logic        busy_event,
    input wire logic        iout_oc_event,
    input wire logic        temp_event,
    input wire logic        other_event,
    input wire logic        output_on,
    input wire logic        ramp_start,
    input wire logic        alert_line_n_o,
    input wire logic        alert_line_n_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_ack_after_req: assert property ((cmd_wr || cmd_rd) |=> cmd_ack)
        else $error("request not answered next cycle");
    a_ack_needs_req: assert property (cmd_ack |-> $past(cmd_wr || cmd_rd))
        else $error("answer without request");
    a_err_with_ack: assert property (cmd_err |-> cmd_ack)
        else $error("refusal outside an answer");
    a_alert_drive_low: assert property (!alert_line_n_o)
        else $error("alert driven high");
    a_event_alert_low: assert property ((busy_event || iout_oc_event || temp_event
        || other_event) |=> alert_line_n_oe)
        else $error("fault event did not pull alert");
    a_ramp_one_pulse: assert property (ramp_start |=> !ramp_start)
        else $error("ramp start longer than one cycle");
    a_rise_has_ramp: assert property ($rose(output_on) |-> ramp_start)
        else $error("output on without ramp start");
    a_rdata_hold: assert property (!(cmd_rd && !cmd_wr) |=> $stable(cmd_rdata))
        else $error("read data changed without a read");
    a_off_no_enable: assert property ((!bus_enable && !ctrl_pin && !group_enable)[*4]
        |-> !output_on)
        else $error("output on with no enable");
endmodule
bind pfl_regs pfl_regs_assertions #(.DELAY_STEP_CYCLES(DELAY_STEP_CYCLES)) chk_i (
    .mclk(mclk), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .cmd_ack(cmd_ack), .cmd_err(cmd_err), .bus_enable(bus_enable), .ctrl_pin(ctrl_pin),
    .group_enable(group_enable), .busy_event(busy_event), .iout_oc_event(iout_oc_event),
    .temp_event(temp_event), .other_event(other_event), .output_on(output_on),
    .ramp_start(ramp_start), .alert_line_n_o(alert_line_n_o),
    .alert_line_n_oe(alert_line_n_oe));

/* testbench/pfl_regs_tb.sv */
// self-checking bench for the fault, limit and status command registers
`timescale 1ns/1ns
module pfl_regs_tb;
    localparam int STEP = 4;
    logic        mclk, nrst, cmd_wr, cmd_rd, cmd_ack, cmd_err, output_on, ramp_start;
    logic        bus_enable, ctrl_pin, group_enable, share_group, clear_faults, meas_valid;
    logic        alert_line_n_o, alert_line_n_oe;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata;
    logic [9:0]  vin_meas, pout_meas;
    logic [8:0]  ev;
    logic [4:0]  cur_exp;
    int          err_count, samples_checked;
    // pull-up on the shared alert wire
    wire         alert_n = alert_line_n_oe ? alert_line_n_o : 1'b1;
    pfl_regs #(.DELAY_STEP_CYCLES(STEP)) dut (.mclk(mclk), .nrst(nrst), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_ack(cmd_ack), .cmd_err(cmd_err), .bus_enable(bus_enable), .ctrl_pin(ctrl_pin),
        .group_enable(group_enable), .share_group(share_group), .clear_faults(clear_faults),
        .meas_valid(meas_valid), .vin_meas(vin_meas), .pout_meas(pout_meas),
        .current_exponent_setting(cur_exp), .busy_event(ev[0]), .vout_ov_event(ev[1]),
        .vout_other_event(ev[2]), .iout_oc_event(ev[3]), .input_other_event(ev[4]),
        .temp_event(ev[5]), .cml_event(ev[6]), .mfr_event(ev[7]), .other_event(ev[8]),
        .output_on(output_on), .ramp_start(ramp_start), .alert_line_n_o(alert_line_n_o),
        .alert_line_n_oe(alert_line_n_oe));
    pfl_host h (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_err(cmd_err));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic io(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input logic ee, input logic [15:0] eq);
        logic a, e;
        logic [15:0] q;
        h.xfer(w, c, d, a, e, q);
        chk({14'h0, a, e}, {14'h0, 1'b1, ee});
        if (!w) chk(q, eq);
    endtask
    task automatic clr;
        @(posedge mclk) clear_faults <= 1'b1;
        @(posedge mclk) clear_faults <= 1'b0;
        tick(2);
        chk({15'h0, alert_n}, 16'h0001);
    endtask
    task automatic t_reset;
        @(posedge mclk);
        nrst <= 1'b0;
        {bus_enable, ctrl_pin, group_enable, share_group, clear_faults, meas_valid} <= '0;
        {vin_meas, pout_meas, ev} <= '0;
        tick(10);
        nrst <= 1'b1;
        io(0, 8'h59, 0, 0, 16'hE800);
        io(0, 8'h5A, 0, 0, 16'h0000);
        io(0, 8'h60, 0, 0, 16'h0000);
        io(0, 8'h68, 0, 0, 16'h0BFF);
        io(0, 8'h69, 0, 0, 16'h0000);
        io(0, 8'h78, 0, 0, 16'h0040);
        chk({15'h0, alert_n}, 16'h0001);
        $display("reset test done");
    endtask
    task automatic t_thresh;
        io(1, 8'h59, 16'hE92A, 0, 0);
        io(0, 8'h59, 0, 0, 16'hE92A);
        io(1, 8'h59, 16'hF001, 1, 0);
        io(0, 8'h59, 0, 0, 16'hE92A);
        io(1, 8'h59, 16'h0055, 0, 0);
        io(0, 8'h59, 0, 0, 16'hE855);
        io(1, 8'h68, 16'h0955, 0, 0);
        io(0, 8'h68, 0, 0, 16'h0955);
        @(posedge mclk) cur_exp <= 5'h1E;
        io(0, 8'h68, 0, 0, 16'hF155);
        @(posedge mclk) cur_exp <= 5'h01;
        io(1, 8'h68, 16'hE800, 1, 0);
        io(1, 8'h78, 0, 1, 0);
        io(0, 8'h12, 0, 1, 0);
        io(0, 8'h78, 0, 0, 16'h0042);
        clr();
        $display("threshold test done");
    endtask
    task automatic t_actions;
        logic [7:0] code [5] = '{8'h80, 8'h40, 8'h00, 8'hC0, 8'h01};
        logic [7:0] back [5] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 5; i++) begin
                io(1, r ? 8'h69 : 8'h5A, {8'h0, code[i]}, i % 2 == 1 || i == 4, 0);
                io(0, r ? 8'h69 : 8'h5A, 0, 0, {8'h0, back[i]});
            end
        end
        clr();
        $display("action test done");
    endtask
    task automatic t_delay(input logic [7:0] d, input int src, input int exp);
        int n;
        io(1, 8'h60, {8'h0, d}, 0, 0);
        @(posedge mclk);
        share_group <= (src >= 2);
        bus_enable <= (src == 0 || src == 3);
        ctrl_pin <= (src == 1);
        group_enable <= (src == 2);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!output_on && n < 2000);
        chk(16'(n >= exp && n <= exp + 1), 16'h0001);
        @(posedge mclk) {bus_enable, ctrl_pin, group_enable, share_group} <= '0;
        tick(5);
        chk({15'h0, output_on}, 16'h0000);
        $display("delay test done");
    endtask
    task automatic t_uv_latch;
        io(1, 8'h59, 16'hE900, 0, 0);
        io(1, 8'h5A, 16'h0080, 0, 0);
        io(1, 8'h60, 0, 0, 0);
        @(posedge mclk) bus_enable <= 1'b1;
        tick(3);
        @(posedge mclk) {meas_valid, vin_meas} <= {1'b1, 10'h100};
        @(posedge mclk) vin_meas <= 10'h0FF;
        @(posedge mclk) meas_valid <= 1'b0;
        chk({15'h0, output_on}, 16'h0001);
        tick(1);
        chk({14'h0, output_on, alert_n}, 16'h0000);
        io(0, 8'h78, 0, 0, 16'h0048);
        io(0, 8'h79, 0, 0, 16'h2048);
        clr();
        chk({15'h0, output_on}, 16'h0000);
        @(posedge mclk) bus_enable <= 1'b0;
        tick(2);
        @(posedge mclk) bus_enable <= 1'b1;
        tick(3);
        io(0, 8'h78, 0, 0, 16'h0000);
        $display("latch test done");
    endtask
    task automatic t_op_ignore;
        io(1, 8'h68, 16'h0200, 0, 0);
        io(1, 8'h69, 16'h0000, 0, 0);
        @(posedge mclk) {meas_valid, vin_meas, pout_meas} <= {1'b1, 10'h3FF, 10'h200};
        @(posedge mclk) pout_meas <= 10'h201;
        @(posedge mclk) meas_valid <= 1'b0;
        chk({15'h0, alert_n}, 16'h0001);
        tick(2);
        chk({14'h0, output_on, alert_n}, 16'h0002);
        io(0, 8'h78, 0, 0, 16'h0001);
        io(0, 8'h79, 0, 0, 16'h4001);
        clr();
        @(posedge mclk) bus_enable <= 1'b0;
        tick(4);
        $display("ignore test done");
    endtask
    task automatic t_events;
        logic [15:0] ex [9] = '{16'h00C0, 16'h8060, 16'h8041, 16'h4050, 16'h2041,
                               16'h0044, 16'h0042, 16'h1041, 16'h0041};
        for (int i = 0; i < 9; i++) begin
            @(posedge mclk) ev <= 9'(1 << i);
            @(posedge mclk) ev <= '0;
            tick(1);
            chk({15'h0, alert_n}, 16'h0000);
            io(0, 8'h79, 0, 0, ex[i]);
            clr();
        end
        $display("event test done");
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        results();
    end
    initial begin
        err_count = 0;
        samples_checked = 0;
        nrst = 1'b0;
        {bus_enable, ctrl_pin, group_enable, share_group, clear_faults, meas_valid} = '0;
        {vin_meas, pout_meas, ev} = '0;
        cur_exp = 5'h01;
        t_reset();
        t_thresh();
        t_actions();
        t_delay(8'h00, 0, 2);
        t_delay(8'h03, 0, 2 + 3 * STEP);
        t_delay(8'hFF, 0, 2 + 255 * STEP);
        t_delay(8'h03, 1, 4 + 3 * STEP);
        t_delay(8'h03, 2, 2);
        t_delay(8'h03, 3, 2 + 3 * STEP);
        t_uv_latch();
        t_op_ignore();
        t_events();
        t_reset();
        results();
    end
endmodule
